/* File: sadc_pkg.sv */
// Package for the successive-approximation converter control block.
// Assumes a 50 MHz pclk and an APB master with 32-bit data.
package sadc_pkg;

   // ***********************************************************
   // Register map (byte addresses)
   // ***********************************************************
   localparam logic [7:0] SADC_CTRL_OFF = 8'h00;
   localparam logic [7:0] SADC_CHAN_OFF = 8'h04;
   localparam logic [7:0] SADC_STAT_OFF = 8'h08;
   localparam logic [7:0] SADC_RES0_OFF = 8'h10;

   // ***********************************************************
   // Control field positions
   // ***********************************************************
   localparam int SADC_CTL_ON = 0;
   localparam int SADC_CTL_RES12 = 1;
   localparam int SADC_CTL_FMT = 2;
   localparam int SADC_CTL_TRIG = 4;
   localparam int SADC_CTL_SCAN = 6;
   localparam int SADC_CTL_FILL = 7;
   localparam int SADC_CTL_START = 8;
   localparam int SADC_CTL_NSH = 9;

   // Reset values
   localparam logic [10:0] SADC_CTRL_RST = 11'h000;
   localparam logic [31:0] SADC_CHAN_RST = 32'h0000_0000;

   // ***********************************************************
   // Timing constants
   // ***********************************************************
   localparam int SADC_CLK_MHZ = 50;
   localparam int SADC_SAMP_NS = 100;
   localparam int SADC_SAMP_CYC = (SADC_SAMP_NS * SADC_CLK_MHZ + 999) / 1000;
   localparam int SADC_TAD_CYC = 2;

   // Trigger sources
   localparam logic [1:0] SADC_TRG_SW = 2'h0;
   localparam logic [1:0] SADC_TRG_EXT = 2'h1;
   localparam logic [1:0] SADC_TRG_PTG = 2'h2;
   localparam logic [1:0] SADC_TRG_AUTO = 2'h3;

   // Result formats
   localparam logic [1:0] SADC_FMT_UINT = 2'h0;
   localparam logic [1:0] SADC_FMT_SINT = 2'h1;
   localparam logic [1:0] SADC_FMT_UFRC = 2'h2;
   localparam logic [1:0] SADC_FMT_SFRC = 2'h3;

   // Sequencer states
   typedef enum logic [3:0] {
      SADC_IDLE = 4'h1,
      SADC_SAMP = 4'h2,
      SADC_CONV = 4'h4,
      SADC_STORE = 4'h8
   } sadc_state_t;

endpackage

/* File: sadc_fmt.sv */
// Result formatter for the converter control block.
// Assumes a raw unsigned code right-aligned in a 12-bit field.
`timescale 1ns/10ps
module sadc_fmt (
   // Raw result
   input wire logic [11:0] raw,
   input wire logic res12,
   input wire logic [1:0] fmt,
   // Formatted word
   output logic [15:0] word
);
   import sadc_pkg::*;

   logic [11:0] mid;
   logic [11:0] sgn;

   // Midscale offset gives the signed form
   always_comb begin
      mid = res12 ? 12'h800 : 12'h200;
      sgn = raw ^ mid;
      case (fmt)
         SADC_FMT_UINT: word = {4'h0, raw};
         SADC_FMT_SINT: word = res12 ? {{4{sgn[11]}}, sgn}
                                     : {{6{sgn[9]}}, sgn[9:0]};
         SADC_FMT_UFRC: word = res12 ? {raw, 4'h0} : {raw[9:0], 6'h00};
         SADC_FMT_SFRC: word = res12 ? {sgn, 4'h0} : {sgn[9:0], 6'h00};
         default: word = 16'h0000;
      endcase
   end
endmodule

/* File: sadc_ctrl.sv */
// Converter control: APB registers, channel select and SAR sequencer.
// Assumes an analog comparator result on cmp_hi, valid one cycle after dac.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/10ps

// What this block does
// - Resolution bit picks 10-bit four S&H or 12-bit one S&H.
// - 12-bit mode samples only one channel, never simultaneously.
// - 10-bit mode samples up to four inputs or op amps together.
// - Channel select addresses inputs 0 to 15.
// - Pins claimed by op amp, comparator or reference are not converted.
// - Results formatted signed/unsigned, fractional/integer.
// - Auto scan, selectable trigger source, selectable buffer fill.
// - Peripheral trigger generator may select channel and trigger.
// - Internal charge-time unit and temperature diode inputs selectable.
// - Conversion continues in core sleep and idle.
// - Rate up to 1.1 Msps at 10-bit, 500 ksps at 12-bit.
module sadc_ctrl #(
   parameter int NCH = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Triggers
   input wire logic ext_trig,
   input wire logic peripheral_trigger_gen_trig,
   input wire logic [3:0] peripheral_trigger_gen_chan,
   // Pin ownership and power state
   input wire logic [NCH-1:0] pin_claimed,
   input wire logic core_sleep,
   // Analog front end
   input wire logic cmp_hi,
   output logic [3:0] sh_sample,
   output logic [3:0] mux_sel,
   output logic mux_int,
   output logic [11:0] dac,
   output logic busy
);
   import sadc_pkg::*;

   // ***********************************************************
   // Programmer's view
   // ***********************************************************
   // Control word: b0 on, b1 12-bit select, b3:2 result format,
   // b5:4 trigger source, b6 scan, b7 fill walk, b8 start (clears
   // itself), b10:9 number of S&H inputs less one (10-bit only).
   // Channel word: b3:0 input number, b31 picks the internal source.
   // Status word: b0 done, b1 overrun, write 1 to clear; a store in
   // the same cycle wins, so no finished result goes unreported.
   // Result slots 0 to 3 hold formatted words in their low half.
   // Each access takes one wait state; unmapped offsets answer with
   // pslverr and change nothing.
   //
   // A conversion samples for a fixed count of cycles, then tests
   // one bit per conversion clock from the top down. The comparator
   // answers a cycle after the trial code appears, which is why one
   // conversion clock spans two cycles. Several S&H inputs share the
   // one SAR, so with four inputs the result is stored four times.
   // Limitation: the resolution lock looks at the on bit only; turn
   // the converter off and wait for busy to drop before switching.

   // ***********************************************************
   // State
   // ***********************************************************
   typedef struct packed {
      logic [10:0] ctrl;
      logic [31:0] chan;
      sadc_state_t st;
      logic [7:0] cnt;
      logic [3:0] bitn;
      logic [11:0] sar;
      logic [1:0] shn;
      logic [1:0] wr;
      logic [15:0] res0;
      logic [15:0] res1;
      logic [15:0] res2;
      logic [15:0] res3;
      logic [3:0] scan_ch;
      logic done;
      logic ovr;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [3:0] sh_sample;
      logic [3:0] mux_sel;
      logic mux_int;
      logic busy;
   } sadc_regs_t;

   sadc_regs_t r_ff;
   sadc_regs_t nxt_r;
   logic [15:0] fword;
   logic res12;
   logic trig;
   logic [3:0] sel_ch;
   logic [3:0] nbits;
   logic acc;

   assign res12 = r_ff.ctrl[SADC_CTL_RES12];
   assign acc = psel & penable;

   // Formatter on the settled SAR code
   sadc_fmt u_fmt (
      .raw(r_ff.sar),
      .res12(res12),
      .fmt(r_ff.ctrl[SADC_CTL_FMT +: 2]),
      .word(fword)
   );

   // ***********************************************************
   // Trigger and channel selection
   // ***********************************************************
   // Source select; sleep is not looked at so conversion keeps going
   always_comb begin
      case (r_ff.ctrl[SADC_CTL_TRIG +: 2])
         SADC_TRG_SW: trig = r_ff.ctrl[SADC_CTL_START];
         SADC_TRG_EXT: trig = ext_trig;
         SADC_TRG_PTG: trig = peripheral_trigger_gen_trig;
         SADC_TRG_AUTO: trig = 1'b1;
         default: trig = 1'b0;
      endcase
      if (r_ff.ctrl[SADC_CTL_TRIG +: 2] == SADC_TRG_PTG) begin
         sel_ch = peripheral_trigger_gen_chan;
      end else if (r_ff.ctrl[SADC_CTL_SCAN]) begin
         sel_ch = r_ff.scan_ch;
      end else begin
         sel_ch = r_ff.chan[3:0];
      end
      nbits = res12 ? 4'd12 : 4'd10;
   end

   // ***********************************************************
   // Next-state logic
   // ***********************************************************
   always_comb begin
      nxt_r = r_ff;
      nxt_r.pready = 1'b0;
      nxt_r.pslverr = 1'b0;
      nxt_r.ctrl[SADC_CTL_START] = 1'b0;
      // APB answers in the access cycle's following edge
      if (acc && !r_ff.pready) begin
         nxt_r.pready = 1'b1;
         nxt_r.prdata = 32'h0000_0000;
         if (pwrite) begin
            case (paddr)
               SADC_CTRL_OFF: begin
                  // Resolution only moves while the converter is off
                  if (r_ff.ctrl[SADC_CTL_ON]) begin
                     nxt_r.ctrl = pwdata[10:0];
                     nxt_r.ctrl[SADC_CTL_RES12] = res12;
                  end else begin
                     nxt_r.ctrl = pwdata[10:0];
                  end
               end
               SADC_CHAN_OFF: nxt_r.chan = pwdata;
               SADC_STAT_OFF: begin
                  // Set wins over clear below
                  if (pwdata[0]) nxt_r.done = 1'b0;
                  if (pwdata[1]) nxt_r.ovr = 1'b0;
               end
               default: nxt_r.pslverr = 1'b1;
            endcase
         end else begin
            case (paddr)
               SADC_CTRL_OFF: nxt_r.prdata = {21'h0, r_ff.ctrl};
               SADC_CHAN_OFF: nxt_r.prdata = r_ff.chan;
               SADC_STAT_OFF: nxt_r.prdata = {24'h0, r_ff.st, r_ff.scan_ch[1:0],
                                              r_ff.ovr, r_ff.done};
               SADC_RES0_OFF: nxt_r.prdata = {16'h0, r_ff.res0};
               8'h14: nxt_r.prdata = {16'h0, r_ff.res1};
               8'h18: nxt_r.prdata = {16'h0, r_ff.res2};
               8'h1c: nxt_r.prdata = {16'h0, r_ff.res3};
               default: nxt_r.pslverr = 1'b1;
            endcase
         end
      end

      // SAR sequencer
      case (r_ff.st)
         SADC_IDLE: begin
            nxt_r.sh_sample = 4'h0;
            if (r_ff.ctrl[SADC_CTL_ON] && trig) begin
               // Claimed pins are skipped, not converted
               if ({1'b0, sel_ch} < 5'(NCH) && !pin_claimed[sel_ch]) begin
                  nxt_r.st = SADC_SAMP;
                  nxt_r.cnt = 8'(SADC_SAMP_CYC);
                  nxt_r.mux_sel = sel_ch;
                  nxt_r.mux_int = r_ff.chan[31];
                  // One S&H in 12-bit, up to four in 10-bit
                  nxt_r.shn = res12 ? 2'd0 : r_ff.ctrl[SADC_CTL_NSH +: 2];
                  case (res12 ? 2'd0 : r_ff.ctrl[SADC_CTL_NSH +: 2])
                     2'd0: nxt_r.sh_sample = 4'h1;
                     2'd1: nxt_r.sh_sample = 4'h3;
                     2'd2: nxt_r.sh_sample = 4'h7;
                     default: nxt_r.sh_sample = 4'hf;
                  endcase
                  nxt_r.wr = 2'd0;
               end
               if (r_ff.ctrl[SADC_CTL_SCAN]) begin
                  nxt_r.scan_ch = r_ff.scan_ch + 4'h1;
               end
            end
         end
         SADC_SAMP: begin
            nxt_r.cnt = r_ff.cnt - 8'h01;
            if (r_ff.cnt == 8'h01) begin
               nxt_r.sh_sample = 4'h0;
               nxt_r.st = SADC_CONV;
               nxt_r.bitn = nbits - 4'h1;
               nxt_r.sar = 12'h000;
               nxt_r.sar[nbits - 4'h1] = 1'b1;
               nxt_r.cnt = 8'(SADC_TAD_CYC);
            end
         end
         SADC_CONV: begin
            // One bit per conversion clock, MSB first
            nxt_r.cnt = r_ff.cnt - 8'h01;
            if (r_ff.cnt == 8'h01) begin
               nxt_r.cnt = 8'(SADC_TAD_CYC);
               if (!cmp_hi) nxt_r.sar[r_ff.bitn] = 1'b0;
               if (r_ff.bitn == 4'h0) begin
                  nxt_r.st = SADC_STORE;
               end else begin
                  nxt_r.bitn = r_ff.bitn - 4'h1;
                  nxt_r.sar[r_ff.bitn - 4'h1] = 1'b1;
               end
            end
         end
         SADC_STORE: begin
            // Fill mode 0 always writes slot 0, 1 walks the slots
            case (r_ff.ctrl[SADC_CTL_FILL] ? r_ff.wr : 2'd0)
               2'd0: nxt_r.res0 = fword;
               2'd1: nxt_r.res1 = fword;
               2'd2: nxt_r.res2 = fword;
               default: nxt_r.res3 = fword;
            endcase
            if (r_ff.done) nxt_r.ovr = 1'b1;
            nxt_r.done = 1'b1;
            nxt_r.wr = r_ff.wr + 2'd1;
            // Further S&H channels share the one SAR, one after another
            nxt_r.st = (r_ff.wr == r_ff.shn) ? SADC_IDLE : SADC_STORE;
         end
         default: nxt_r.st = SADC_IDLE;
      endcase
      // Busy is kept in a flop so the pin carries no decode glitch;
      // it follows the state that the next edge will load
      nxt_r.busy = (nxt_r.st != SADC_IDLE);
   end

   // ***********************************************************
   // State register
   // ***********************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_ff <= '{ctrl: SADC_CTRL_RST, chan: SADC_CHAN_RST, st: SADC_IDLE,
                   default: '0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   // Outputs straight from flip-flops
   assign prdata = r_ff.prdata;
   assign pready = r_ff.pready;
   assign pslverr = r_ff.pslverr;
   assign sh_sample = r_ff.sh_sample;
   assign mux_sel = r_ff.mux_sel;
   assign mux_int = r_ff.mux_int;
   assign dac = r_ff.sar;
   assign busy = r_ff.busy;

   // ***********************************************************
   // Checks
   // ***********************************************************
   // A 12-bit conversion never drives more than one S&H
   one_sh_a: assert property (@(posedge pclk) disable iff (!presetn)
      res12 |-> $countones(sh_sample) <= 1)
      else $error("more than one S&H in 12-bit mode");
   // Resolution only moves while the converter is off
   res_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
      r_ff.ctrl[SADC_CTL_ON] && $past(r_ff.ctrl[SADC_CTL_ON]) |-> $stable(res12))
      else $error("resolution changed while on");
   // First trial of every conversion is the top bit of its code
   sar_msb_a: assert property (@(posedge pclk) disable iff (!presetn)
      r_ff.st == SADC_SAMP && nxt_r.st == SADC_CONV |=> dac[nbits - 4'h1])
      else $error("MSB not trial set");
   // A claimed pin never reaches the sampling phase
   pin_claim_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      r_ff.st == SADC_IDLE && nxt_r.st == SADC_SAMP |-> !pin_claimed[sel_ch])
      else $error("claimed pin converted");

   // ***********************************************************
   // Sequencer checks
   // ***********************************************************
   // In 10-bit mode the sampled set matches the programmed count
   sh_count_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !res12 && r_ff.st == SADC_SAMP |->
         $countones(sh_sample) == int'(r_ff.shn) + 1)
      else $error("S&H count differs from setting");
   // A 10-bit code stays inside its ten bits while converting
   code_width_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !res12 && r_ff.st == SADC_CONV |-> dac[11:10] == 2'b00)
      else $error("10-bit code uses upper bits");
   // Bits below the trial bit stay clear: the search runs MSB first
   lower_clear_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      r_ff.st == SADC_CONV |->
         (r_ff.sar & ((12'h001 << r_ff.bitn) - 12'h001)) == 12'h000)
      else $error("bits below the trial bit are set");
   // Sampling plus all bit tests fit the 10-bit rate budget, which
   // is the tighter one, so both resolutions are held to it
   conv_rate_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      r_ff.st == SADC_IDLE && nxt_r.st == SADC_SAMP |->
         ##[24:44] r_ff.st == SADC_STORE)
      else $error("conversion too slow");
   // A conversion in progress runs on while the core sleeps
   sleep_run_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      core_sleep && r_ff.st == SADC_CONV |=> r_ff.st != SADC_IDLE)
      else $error("conversion dropped in sleep");
   // The trigger generator's channel is the one put on the mux
   ptg_chan_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      r_ff.ctrl[SADC_CTL_TRIG +: 2] == SADC_TRG_PTG &&
         r_ff.st == SADC_IDLE && nxt_r.st == SADC_SAMP |=>
         mux_sel == $past(peripheral_trigger_gen_chan))
      else $error("trigger generator channel not selected");
   // Each scan trigger moves to the next input
   scan_step_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      r_ff.st == SADC_IDLE && r_ff.ctrl[SADC_CTL_ON] && trig &&
         r_ff.ctrl[SADC_CTL_SCAN] |=>
         r_ff.scan_ch == $past(r_ff.scan_ch) + 4'h1)
      else $error("scan did not advance");
   // Without fill walk slot 3 is not written
   fill_slot_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      r_ff.st == SADC_STORE && !r_ff.ctrl[SADC_CTL_FILL] |=>
         $stable(r_ff.res3))
      else $error("slot written without fill walk");
endmodule

/* File: sadc_afe_model.sv */
// Analog front end stand-in: comparator answering the SAR code on dac.
// Assumes mux_sel picks a pin level and cmp_hi is sampled a cycle later.
`timescale 1ns/10ps
module sadc_afe_model (
   // Clock
   input wire logic pclk,
   // Selection and trial code
   input wire logic [3:0] mux_sel,
   input wire logic mux_int,
   input wire logic [11:0] dac,
   // Comparator out
   output logic cmp_hi
);
   logic [11:0] lvl;
   // Fixed pin levels; the internal source reads 12'h0f0
   always_comb begin
      case (mux_sel)
         4'h5: lvl = 12'h2a5;
         4'h9: lvl = 12'habc;
         default: lvl = 12'h155;
      endcase
      if (mux_int) begin
         lvl = 12'h0f0;
      end
   end
   // Registered, so the answer lags the trial code by one cycle
   always @(posedge pclk) begin
      cmp_hi <= (lvl >= dac);
   end
endmodule

/* File: sar_adc_control_tb_top.sv */
// Testbench for the converter control block, driven over APB.
// Assumes the comparator model in sadc_afe_model.
`timescale 1ns/10ps
module sar_adc_control_tb_top;
   import sadc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, cmp_hi, mux_int, busy;
   logic ext_trig = 0, ptg_trig = 0, core_sleep = 0, got = 0, int_seen;
   logic [3:0] ptg_chan = 4'h0, sh_sample, mux_sel, sh_or, mux_seen;
   logic [15:0] pin_claimed = 16'h0;
   logic [11:0] dac, first_dac;
   int n_fail = 0, num_checks = 0, cyc, tmo = 0;
   sadc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_trig(ext_trig), .peripheral_trigger_gen_trig(ptg_trig),
      .peripheral_trigger_gen_chan(ptg_chan), .pin_claimed(pin_claimed),
      .core_sleep(core_sleep), .cmp_hi(cmp_hi), .sh_sample(sh_sample),
      .mux_sel(mux_sel), .mux_int(mux_int), .dac(dac), .busy(busy));
   sadc_afe_model afe (.pclk(pclk), .mux_sel(mux_sel), .mux_int(mux_int),
      .dac(dac), .cmp_hi(cmp_hi));
   // 50 MHz clock
   always #10 pclk = ~pclk;
   // Watch the front end while a conversion runs
   always @(posedge pclk) begin
      if (busy === 1'b1) begin
         cyc++;
         sh_or = sh_or | sh_sample;
         mux_seen = mux_sel;
         int_seen = int_seen | mux_int;
         if (!got && dac !== 12'h000) begin
            got = 1;
            first_dac = dac;
         end
      end
      // Ceiling on the run; a hang ends here as a failure
      tmo++;
      if (tmo == 30000) begin
         n_fail++;
         wrap_up();
      end
   end
   // ***********************************************************
   // Bus and compare tasks
   // ***********************************************************
   // Holds the request until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task chk(input logic [31:0] exp, input logic [31:0] got_v);
      num_checks++;
      if (exp !== got_v) begin
         n_fail++;
         $display("CHECK FAILED t=%0t exp %h got %h", $time, exp, got_v);
      end
   endtask
   task chk_max(input int lim, input int meas);
      num_checks++;
      if (meas > lim) begin
         n_fail++;
         $display("CHECK FAILED t=%0t took %0d > %0d", $time, meas, lim);
      end
   endtask
   // Start through a control write or a pin pulse, wait for done
   task conv(input logic [31:0] c, input int pin);
      cyc = 0;
      sh_or = 0;
      int_seen = 0;
      apb(1, SADC_CTRL_OFF, c);
      if (pin == 1) ext_trig <= 1;
      if (pin == 2) ptg_trig <= 1;
      @(posedge pclk);
      ext_trig <= 0;
      ptg_trig <= 0;
      rd = 0;
      for (int i = 0; i < 100 && rd[0] !== 1'b1; i++) apb(0, SADC_STAT_OFF, 0);
      chk(1, rd[0]);
      apb(1, SADC_STAT_OFF, 32'h3);
   endtask
   task wrap_up();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ***********************************************************
   // Test sequence
   // ***********************************************************
   logic [15:0] fexp [4] = '{16'h02a5, 16'h00a5, 16'ha940, 16'h2940};
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      apb(0, SADC_CTRL_OFF, 0);
      chk(0, rd);
      apb(0, 8'h0c, 0);
      chk(1, err);
      apb(1, SADC_CHAN_OFF, 32'h5);
      for (int f = 0; f < 4; f++) begin
         conv(32'h101 | (f << 2), 0);
         apb(0, SADC_RES0_OFF, 0);
         chk(fexp[f], rd);
         if (f == 0) chk(12'h200, first_dac);
         chk_max(45, cyc);
      end
      apb(1, SADC_CTRL_OFF, 32'h3);
      apb(0, SADC_CTRL_OFF, 0);
      chk(0, rd[1]);
      apb(1, SADC_CTRL_OFF, 0);
      apb(1, SADC_CTRL_OFF, 32'h2);
      apb(1, SADC_CHAN_OFF, 32'h9);
      conv(32'h703, 0);
      apb(0, SADC_RES0_OFF, 0);
      chk(12'habc, rd);
      chk(1, $onehot(sh_or));
      chk_max(100, cyc);
      apb(1, SADC_CTRL_OFF, 0);
      core_sleep <= 1;
      conv(32'h701, 0);
      chk(4'hf, sh_or);
      core_sleep <= 0;
      ptg_chan <= 4'hc;
      conv(32'h061, 2);
      chk(4'hc, mux_seen);
      apb(1, SADC_CHAN_OFF, 32'h8000_0000);
      conv(32'h011, 1);
      chk(1, int_seen);
      // A claimed pin must not start a conversion
      apb(1, SADC_CHAN_OFF, 32'h5);
      pin_claimed <= 16'h0020;
      apb(1, SADC_CTRL_OFF, 32'h101);
      repeat (40) @(posedge pclk);
      apb(0, SADC_STAT_OFF, 0);
      chk(0, rd[0]);
      pin_claimed <= 16'h0000;
      // Free-running trigger with fill walk over four S&H inputs
      conv(32'h6b1, 0);
      apb(1, SADC_CTRL_OFF, 0);
      apb(0, SADC_RES0_OFF + 8'h0c, 0);
      chk(16'h02a5, rd);
      wrap_up();
   end
endmodule
